//--- hw/cbd_pkg.sv
// constants for the cpu bus decode and handshake block
package cbd_pkg;

  // clock rates; the bus wait-state shifter runs at the slower system rate
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SYS_CLK_HZ = 6_000_000;
  // integer divide rounds down, so the tick is 6.25 MHz rather than 6 MHz
  localparam int unsigned SYS_DIV = CLK_HZ / SYS_CLK_HZ;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);

  // power-on reset pulse, 0.5 s
  localparam int unsigned RESET_PULSE_MS = 500;
  localparam int unsigned RESET_PULSE_CYC = (CLK_HZ / 1000) * RESET_PULSE_MS;
  localparam int RST_CNT_W = 25;

  // upper address nibble (bits 23..20) that enables the select decoder
  localparam logic [3:0] DECODE_REGION = 4'h0;

  // select map, indexed by address bits 19..16
  localparam logic [3:0] ROM_SEL = 4'h0;
  localparam logic [3:0] BATT_RAM_SEL = 4'h1;
  localparam logic [3:0] UNBUF_SEL_LAST = 4'h1;
  localparam logic [3:0] MEM_SEL_LAST = 4'h7;
  localparam logic [3:0] IO_SEL_FIRST = 4'h8;
  localparam logic [3:0] IO_SEL_LAST = 4'hd;
  localparam logic [3:0] PERIPH_SEL_A = 4'he;
  localparam logic [3:0] PERIPH_SEL_B = 4'hf;
  localparam logic [3:0] RTC_SEL = 4'hf;

  // i/o wait-state shifter: tap three raises the strobe, tap four the ack
  localparam int SHIFT_W = 4;
  localparam int TAP_STROBE = 2;
  localparam int TAP_ACK = 3;
  localparam logic [3:0] SHIFT_CLEAR = 4'h0;

  // reset sequencer states
  typedef enum logic [1:0] {
    RST_ACTIVE = 2'b00,
    RST_RUN = 2'b01
  } cbd_rst_state_e;

endpackage

//--- hw/cbd_top.sv
// address decode, transfer handshake, reset/halt and interrupt level encoder
// Functional notes
// - upper address bits 23..20, qualified by address strobe, enable the decoder.
// - when enabled and not masked by power fail, address bits 19..16 assert exactly one of sixteen selects.
// - selects 0-7 memories, 8-13 i/o, 14-15 peripheral handshake devices.
// - memory selects return transfer acknowledge immediately, no wait states.
// - i/o selects start shifter at system rate; third tick raises analog strobe.
// - one tick after the analog strobe, delayed transfer acknowledge asserts.
// - selects 14 or 15 assert the peripheral cycle request.
// - peripheral request also takes an external input and interrupt acknowledges.
// - active-low flag whenever the target lies outside the unbuffered region.
// - byte strobes gate read/write into separate upper/lower write and output enables.
// - power fail forces the battery-backed memory select inactive.
// - power-on or reset button gives a 0.5 s pulse to reset and halt.
// - reset and halt are driven open-drain; the processor may drive reset.
// - power fail halts the processor.
// - seven active-low requests encode to the highest pending level number.
// - power fail drives level seven; the clock tick drives level one.
// - bus buffers enabled on every access not to unbuffered memory.
// - data buffer direction follows read/write.
// - the real time clock periodic interrupt enters on request line 1.
// - power fail holds the real time clock select inactive.
`timescale 1ns/100ps
module cbd_top #(
  parameter int unsigned RESET_PULSE_CYCLES = cbd_pkg::RESET_PULSE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic addr_valid_strobe_n,
  input wire logic [7:0] addr_hi,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic read_write,
  input wire logic int_ack_cycle,
  input wire logic transfer_ack_ext_n,
  input wire logic periph_req_ext_n,
  input wire logic power_fail,
  input wire logic reset_button,
  input wire logic delay_halt_req_n,
  input wire logic cpu_reset_in_n,
  input wire logic [7:2] irq_line_ext_n,
  input wire logic irq_line_1_n,
  output logic [15:0] dev_select_n,
  output logic transfer_ack_n,
  output logic analog_dev_strobe_n,
  output logic peripheral_cycle_req_n,
  output logic outside_addr_n,
  output logic buffer_enable_n,
  output logic buffer_dir_read,
  output logic upper_we_n,
  output logic lower_we_n,
  output logic upper_oe_n,
  output logic lower_oe_n,
  output logic cpu_reset_out,
  output logic cpu_reset_oe,
  output logic cpu_halt_out,
  output logic cpu_halt_oe,
  output logic [2:0] prio_level_n
);
  import cbd_pkg::*;

  // one-hot image of a select index
  function automatic logic [15:0] sel_onehot(input logic [3:0] idx);
    sel_onehot = 16'h0001 << idx;
  endfunction

  // number of the highest pending request, zero when none
  function automatic logic [2:0] prio_encode(input logic [7:1] req);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 1; i <= 7; i++) begin
      if (req[i]) begin
        lvl = 3'(i);
      end
    end
    prio_encode = lvl;
  endfunction

  logic [3:0] div_cnt_reg;
  logic [SHIFT_W-1:0] io_shift_reg;
  logic [SHIFT_W-1:0] io_shift_next;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  cbd_rst_state_e rst_state_reg;
  cbd_rst_state_e rst_state_next;
  logic [15:0] dev_select_reg;
  logic transfer_ack_reg;
  logic analog_strobe_reg;
  logic periph_req_reg;
  logic outside_reg;
  logic buf_en_reg;
  logic buf_dir_reg;
  logic upper_we_reg;
  logic lower_we_reg;
  logic upper_oe_reg;
  logic lower_oe_reg;
  logic reset_oe_reg;
  logic halt_oe_reg;
  logic [2:0] prio_reg;

  // address decode
  wire strobe_on = ~addr_valid_strobe_n;
  wire [3:0] sel_idx = addr_hi[3:0];
  wire decode_en = strobe_on && (addr_hi[7:4] == DECODE_REGION);
  wire [15:0] sel_vec = decode_en ? sel_onehot(sel_idx) : 16'h0000;
  wire is_mem = decode_en && (sel_idx <= MEM_SEL_LAST);
  wire is_io = decode_en && (sel_idx >= IO_SEL_FIRST) && (sel_idx <= IO_SEL_LAST);
  wire is_periph = decode_en && (sel_idx == PERIPH_SEL_A || sel_idx == PERIPH_SEL_B);
  wire is_unbuf = decode_en && (sel_idx <= UNBUF_SEL_LAST);

  // power fail masks the battery ram and clock selects
  wire [15:0] pf_mask = power_fail ? ~(sel_onehot(BATT_RAM_SEL) | sel_onehot(RTC_SEL))
                                   : 16'hffff;
  wire [15:0] dev_select_next = ~(sel_vec & pf_mask);

  // system-rate tick for the wait-state shifter
  wire sys_tick = (div_cnt_reg == SYS_DIV_LAST);

  // shifter fills with ones while an i/o cycle lasts; a processor-driven
  // reset also clears it so a half-finished cycle cannot ack later
  always_comb begin
    io_shift_next = io_shift_reg;
    if (!is_io || !cpu_reset_in_n) begin
      io_shift_next = SHIFT_CLEAR;
    end else if (sys_tick) begin
      io_shift_next = {io_shift_reg[SHIFT_W-2:0], 1'b1};
    end
  end

  // handshake terms
  wire strobe_next = is_io && io_shift_reg[TAP_STROBE];
  wire ack_next = is_mem || (is_io && io_shift_reg[TAP_ACK])
                  || !transfer_ack_ext_n;
  wire periph_next = is_periph || !periph_req_ext_n
                     || (int_ack_cycle && strobe_on);
  wire outside_next = strobe_on && !is_unbuf;

  // byte lane gating for the unbuffered memory pairs
  wire batt_blocked = power_fail && (sel_idx == BATT_RAM_SEL);
  wire lane_mem = is_unbuf && !batt_blocked;
  wire upper_lane = lane_mem && !upper_byte_strobe_n;
  wire lower_lane = lane_mem && !lower_byte_strobe_n;

  // interrupt requests; power fail on top level, clock tick on bottom
  wire [7:1] irq_req = {(!irq_line_ext_n[7]) || power_fail, ~irq_line_ext_n[6:2],
                        !irq_line_1_n};
  wire [2:0] prio_next = prio_encode(irq_req);

  // reset sequencer
  wire pulse_on = (rst_state_reg == RST_ACTIVE);
  wire pulse_done = (rst_cnt_reg == RST_CNT_W'(RESET_PULSE_CYCLES - 1));
  always_comb begin
    case (rst_state_reg)
      RST_ACTIVE: rst_state_next = pulse_done ? RST_RUN : RST_ACTIVE;
      RST_RUN: rst_state_next = reset_button ? RST_ACTIVE : RST_RUN;
      default: rst_state_next = RST_ACTIVE;
    endcase
  end
  wire halt_next = pulse_on || power_fail || !delay_halt_req_n;

  // divider and reset counter
  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt_reg <= 4'h0;
      rst_cnt_reg <= '0;
      rst_state_reg <= RST_ACTIVE;
    end else begin
      div_cnt_reg <= sys_tick ? 4'h0 : div_cnt_reg + 4'h1;
      rst_cnt_reg <= (rst_state_next == RST_ACTIVE && !pulse_done) ? rst_cnt_reg + 1'b1 : '0;
      rst_state_reg <= rst_state_next;
    end
  end

  // bus handshake registers; every output but the tied-low cpu_reset_out and cpu_halt_out leaves from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      io_shift_reg <= SHIFT_CLEAR;
      dev_select_reg <= 16'hffff;
      transfer_ack_reg <= 1'b0;
      analog_strobe_reg <= 1'b0;
      periph_req_reg <= 1'b0;
      outside_reg <= 1'b0;
      buf_dir_reg <= 1'b1;
    end else begin
      io_shift_reg <= io_shift_next;
      dev_select_reg <= dev_select_next;
      transfer_ack_reg <= ack_next;
      analog_strobe_reg <= strobe_next;
      periph_req_reg <= periph_next;
      outside_reg <= outside_next;
      buf_dir_reg <= read_write;
    end
  end

  // byte enables, buffer enable, reset/halt drive and interrupt level
  always_ff @(posedge clk) begin
    if (reset) begin
      buf_en_reg <= 1'b0;
      upper_we_reg <= 1'b0;
      lower_we_reg <= 1'b0;
      upper_oe_reg <= 1'b0;
      lower_oe_reg <= 1'b0;
      reset_oe_reg <= 1'b1;
      halt_oe_reg <= 1'b1;
      prio_reg <= 3'h0;
    end else begin
      buf_en_reg <= outside_next;
      upper_we_reg <= upper_lane && !read_write;
      lower_we_reg <= lower_lane && !read_write;
      upper_oe_reg <= upper_lane && read_write;
      lower_oe_reg <= lower_lane && read_write;
      reset_oe_reg <= pulse_on;
      halt_oe_reg <= halt_next;
      prio_reg <= prio_next;
    end
  end

  // output mapping; open-drain pins only ever pull low
  assign dev_select_n = dev_select_reg;
  assign transfer_ack_n = !transfer_ack_reg;
  assign analog_dev_strobe_n = !analog_strobe_reg;
  assign peripheral_cycle_req_n = !periph_req_reg;
  assign outside_addr_n = !outside_reg;
  assign buffer_enable_n = !buf_en_reg;
  assign buffer_dir_read = buf_dir_reg;
  assign upper_we_n = !upper_we_reg;
  assign lower_we_n = !lower_we_reg;
  assign upper_oe_n = !upper_oe_reg;
  assign lower_oe_n = !lower_oe_reg;
  assign cpu_reset_out = 1'b0;
  assign cpu_reset_oe = reset_oe_reg;
  assign cpu_halt_out = 1'b0;
  assign cpu_halt_oe = halt_oe_reg;
  assign prio_level_n = ~prio_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_decode_off;
    !decode_en |=> dev_select_n == 16'hffff;
  endproperty
  a_decode_off: assert property (p_decode_off) else $error("select active without decode");

  property p_one_select;
    decode_en && !power_fail |=> dev_select_n == ~sel_onehot($past(sel_idx));
  endproperty
  a_one_select: assert property (p_one_select) else $error("wrong select pattern");

  property p_mem_ack;
    is_mem |=> !transfer_ack_n;
  endproperty
  a_mem_ack: assert property (p_mem_ack) else $error("memory ack not immediate");

  property p_io_strobe;
    is_io && sys_tick && io_shift_reg == 4'h3 ##1 is_io |=> !analog_dev_strobe_n;
  endproperty
  a_io_strobe: assert property (p_io_strobe) else $error("analog strobe late");

  // tap four rises one system tick after tap three; ack follows on the next edge
  property p_ack_after_strobe;
    $rose(io_shift_reg[TAP_ACK]) && is_io |-> $past(io_shift_reg[TAP_STROBE], 8)
      && !analog_dev_strobe_n ##1 !transfer_ack_n;
  endproperty
  a_ack_after_strobe: assert property (p_ack_after_strobe) else $error("io ack spacing");

  property p_io_clear;
    !is_io |=> io_shift_reg == 4'h0 ##1 analog_dev_strobe_n;
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("shifter not cleared");

  property p_periph;
    is_periph |=> !peripheral_cycle_req_n;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral request missing");

  property p_pf_deselect;
    power_fail |=> dev_select_n[1] && dev_select_n[15] && cpu_halt_oe;
  endproperty
  a_pf_deselect: assert property (p_pf_deselect) else $error("power fail not honoured");

  property p_pf_level;
    power_fail |=> prio_level_n == 3'h0;
  endproperty
  a_pf_level: assert property (p_pf_level) else $error("power fail not top level");

  property p_buffers;
    strobe_on && !is_unbuf |=> !buffer_enable_n && !outside_addr_n;
  endproperty
  a_buffers: assert property (p_buffers) else $error("buffers not enabled");

  property p_write_lane;
    is_unbuf && !power_fail && !read_write && !upper_byte_strobe_n
      |=> !upper_we_n && upper_oe_n;
  endproperty
  a_write_lane: assert property (p_write_lane) else $error("upper write lane wrong");

  property p_reset_pulse;
    pulse_on |=> cpu_reset_oe && cpu_halt_oe;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse not driven");

  c_mem_cycle: cover property (is_mem ##1 !transfer_ack_n);
  c_io_cycle: cover property ($fell(analog_dev_strobe_n) ##[1:20] $fell(transfer_ack_n));
  c_periph_cycle: cover property (is_periph ##1 !peripheral_cycle_req_n);
  c_power_fail: cover property ($rose(power_fail) ##1 cpu_halt_oe);

endmodule // cbd_top

//--- test/cbd_ext_dev.sv
// far-side bus device that decodes its own addresses and acknowledges
`timescale 1ns/100ps
module cbd_ext_dev #(
  parameter int DELAY = 3
) (
  input wire logic clk,
  input wire logic addr_valid_strobe_n,
  input wire logic [7:0] addr_hi,
  output logic transfer_ack_ext_n
);
  int cnt = 0;
  logic ack_on = 1'b0;
  wire sel = !addr_valid_strobe_n && addr_hi[7:4] != 4'h0;
  // answers only above the on-board region, a few clocks late like a slow card
  always @(posedge clk) begin
    cnt <= sel ? cnt + 1 : 0;
    ack_on <= #1 sel && cnt >= DELAY;
  end
  // pulled-up ack line lets go as soon as the address strobe negates
  assign transfer_ack_ext_n = !(ack_on && !addr_valid_strobe_n);
endmodule // cbd_ext_dev

//--- test/cpu_bus_decode_handshake_bench.sv
// self-checking bench for the bus decode and handshake block
`timescale 1ns/100ps
module cpu_bus_decode_handshake_bench;
  import cbd_pkg::*;
  typedef struct {logic [23:0] v; int lo; int hi;} cbd_exp_s;
  logic clk = 0, reset = 1, addr_valid_strobe_n = 1, upper_byte_strobe_n = 1;
  logic lower_byte_strobe_n = 1, read_write = 1, int_ack_cycle = 0, transfer_ack_ext_n;
  logic periph_req_ext_n = 1, power_fail = 0, reset_button = 0, delay_halt_req_n = 1;
  logic [7:0] addr_hi = 8'h00;
  logic [6:0] irq_n = 7'h7f;
  logic [15:0] dev_select_n;
  logic transfer_ack_n, analog_dev_strobe_n, peripheral_cycle_req_n, outside_addr_n;
  logic buffer_enable_n, buffer_dir_read, upper_we_n, lower_we_n, upper_oe_n, lower_oe_n;
  logic cpu_reset_oe, cpu_halt_oe, cpu_reset_out, cpu_halt_out, mon_on = 0, prev_done = 1;
  logic cpu_reset_in_n = 1;
  logic [2:0] prio_level_n;
  int err_count = 0, checks_done = 0, cyc = 0, tmo = 0, n;
  cbd_exp_s q[$];
  cbd_exp_s e;
  wire done_n = transfer_ack_n & peripheral_cycle_req_n;
  wire [23:0] seen = {dev_select_n, upper_we_n, lower_we_n, upper_oe_n, lower_oe_n,
    outside_addr_n, buffer_enable_n, buffer_dir_read, analog_dev_strobe_n};

  // short reset pulse count keeps the run brief
  cbd_top #(.RESET_PULSE_CYCLES(20)) i_dut (.clk, .reset, .addr_valid_strobe_n, .addr_hi,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .read_write, .int_ack_cycle,
    .transfer_ack_ext_n, .periph_req_ext_n, .power_fail, .reset_button, .delay_halt_req_n,
    .cpu_reset_in_n, .irq_line_ext_n(irq_n[6:1]), .irq_line_1_n(irq_n[0]),
    .dev_select_n, .transfer_ack_n, .analog_dev_strobe_n, .peripheral_cycle_req_n,
    .outside_addr_n, .buffer_enable_n, .buffer_dir_read, .upper_we_n, .lower_we_n,
    .upper_oe_n, .lower_oe_n, .cpu_reset_out, .cpu_reset_oe, .cpu_halt_out,
    .cpu_halt_oe, .prio_level_n);
  cbd_ext_dev i_ext (.clk, .addr_valid_strobe_n, .addr_hi, .transfer_ack_ext_n);

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    tmo++;
    if (tmo == 5000) begin
      err_count++;
      stop_test();
    end
  end

  // completion watcher: oldest note against what the outputs show
  always begin
    @(posedge clk);
    #2;
    // cyc here counts the edges that have already sampled the strobe low
    if (mon_on && prev_done && !done_n) begin
      if (q.size() == 0) chk("spare completion", 24'h0, 24'h1);
      else begin
        e = q.pop_front();
        chk("bus outputs", e.v, seen);
        chk("wait cycles", 24'h1, {23'h0, cyc >= e.lo && cyc <= e.hi});
      end
    end
    cyc = addr_valid_strobe_n ? 0 : cyc + 1;
    prev_done = done_n;
  end

  // one processor cycle with random direction and byte lanes; notes the outcome
  task automatic bus(logic [7:0] a, int lo, int hi);
    logic rw, ub, lb, ins, unb;
    cbd_exp_s x;
    rw = 1'($urandom);
    {ub, lb} = 2'($urandom_range(2));
    ins = a[7:4] == 4'h0;
    unb = ins && a[3:0] <= 4'h1;
    x.v = {ins ? ~(16'h1 << a[3:0]) : 16'hffff,
      unb ? {rw | ub, rw | lb, !rw | ub, !rw | lb} : 4'hf, unb, unb, rw, !(lo > 20)};
    x.lo = lo;
    x.hi = hi;
    q.push_back(x);
    addr_hi = a;
    read_write = rw;
    upper_byte_strobe_n = ub;
    lower_byte_strobe_n = lb;
    addr_valid_strobe_n = 0;
    for (n = 0; n < 60 && done_n !== 1'b0; n++) @(posedge clk) #1;
    if (n == 60) chk("completion", 24'h0, 24'h1);
    addr_valid_strobe_n = 1;
    upper_byte_strobe_n = 1;
    lower_byte_strobe_n = 1;
    @(posedge clk) #1;
    chk("release", 24'h3, {22'h0, transfer_ack_n, analog_dev_strobe_n});
  endtask

  initial begin
    void'($urandom(32'h556e8922));
    repeat (2) @(posedge clk);
    #1;
    reset = 0;
    // reset pulse length, halt dropping with it
    for (n = 0; n < 100 && cpu_reset_oe !== 1'b0; n++) @(posedge clk) #1;
    chk("reset pulse", 24'h1, {23'h0, n >= 19 && n <= 22});
    chk("halt follows", 24'h0, {23'h0, cpu_halt_oe});
    chk("drive level", 24'h0, {22'h0, cpu_reset_out, cpu_halt_out});
    $display("test reset_pulse done");
    // every select, then an off-board address answered by the far device
    mon_on = 1;
    for (int s = 0; s < 16; s++) bus(8'(s), s < 8 || s > 13 ? 1 : 24, s < 8 || s > 13 ? 1 : 34);
    bus({4'(1 + $urandom_range(14)), 4'($urandom)}, 4, 6);
    mon_on = 0;
    chk("notes left", 24'h0, 24'(q.size()));
    $display("test decode done");
    // power fail: battery memory and clock chip held off, halt and top level
    power_fail = 1;
    addr_valid_strobe_n = 0;
    for (int s = 1; s < 16; s += 14) begin
      addr_hi = 8'(s);
      repeat (2) @(posedge clk) #1;
      chk("fail deselect", 24'h1, {23'h0, dev_select_n[s]});
    end
    chk("fail halt", 24'h1, {23'h0, cpu_halt_oe});
    chk("fail level", 24'h0, {21'h0, prio_level_n});
    addr_valid_strobe_n = 1;
    power_fail = 0;
    $display("test power_fail done");
    // each level with random lower requests pending beneath it
    for (int k = 0; k < 8; k++) begin
      irq_n = k == 0 ? 7'h7f : (7'h7f << k) | (7'($urandom) & ((7'h1 << (k - 1)) - 7'h1));
      repeat (2) @(posedge clk) #1;
      chk("level", {21'h0, 3'(~k)}, {21'h0, prio_level_n});
    end
    irq_n = 7'h7f;
    $display("test interrupts done");
    delay_halt_req_n = 0;
    periph_req_ext_n = 0;
    repeat (2) @(posedge clk) #1;
    chk("halt request", 24'h1, {23'h0, cpu_halt_oe});
    chk("ext periph", 24'h0, {23'h0, peripheral_cycle_req_n});
    delay_halt_req_n = 1;
    periph_req_ext_n = 1;
    int_ack_cycle = 1;
    addr_hi = 8'hff;
    addr_valid_strobe_n = 0;
    repeat (2) @(posedge clk) #1;
    chk("int ack periph", 24'h0, {23'h0, peripheral_cycle_req_n});
    int_ack_cycle = 0;
    addr_valid_strobe_n = 1;
    $display("test halt_periph done");
    // a processor-driven reset keeps an i/o wait from ever acknowledging
    @(posedge clk) #1;
    cpu_reset_in_n = 0;
    addr_hi = 8'h08;
    addr_valid_strobe_n = 0;
    repeat (40) @(posedge clk) #1;
    chk("reset aborts io", 24'h3, {22'h0, transfer_ack_n, analog_dev_strobe_n});
    addr_valid_strobe_n = 1;
    cpu_reset_in_n = 1;
    $display("test reset_abort done");
    reset_button = 1;
    @(posedge clk) #1;
    reset_button = 0;
    repeat (2) @(posedge clk) #1;
    chk("button pulse", 24'h1, {23'h0, cpu_reset_oe});
    $display("test reset_button done");
    stop_test();
  end
endmodule // cpu_bus_decode_handshake_bench
